// [logic/tbx_cfg.svh]
`ifndef TBX_CFG_SVH
`define TBX_CFG_SVH
// termination hold time in ns and watchdog interval in us
`define TBX_TERM_TIME_NS 34000
`define TBX_GUARD_TIME_US 21000
`define TBX_CLK_PERIOD_NS 100
// cycle counts: termination is a least time (round up), guard is a limit (round down)
`define TBX_TERM_CYCLES ((`TBX_TERM_TIME_NS + `TBX_CLK_PERIOD_NS - 1) / `TBX_CLK_PERIOD_NS)
`define TBX_GUARD_CYCLES ((`TBX_GUARD_TIME_US * 1000) / `TBX_CLK_PERIOD_NS)
`define TBX_CNT_W 18
`define TBX_POL_INIT 1'b0
`define TBX_FIFO_DEPTH 16
`endif

// [logic/tbx_pkg.sv]
// Purpose: shared types of the two-wire bus transceiver control
// Assumes: constants live in tbx_cfg.svh
// Notes: line drive state only
package tbx_pkg;
  typedef enum logic [1:0] {TBX_IDLE, TBX_DRIVE, TBX_HOLD} tbx_drv_t;
endpackage

// [logic/tbx_fifo.sv]
// Purpose: small synchronous fifo for the transmit edge stream
// Assumes: one clock, synchronous active high reset
// Notes: read data come from a register; full and empty are exact
`include "tbx_cfg.svh"
module tbx_fifo
  import tbx_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = `TBX_FIFO_DEPTH
)
(
  input wire logic ref_clk, // clock
  input wire logic reset, // sync reset
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // read data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } tbx_fifo_st_t;
  logic [WIDTH-1:0] mem_r [DEPTH];
  tbx_fifo_st_t st_r;
  tbx_fifo_st_t st_nxt;
  logic wr;
  logic rd;
  logic fill;
  // handshakes; output stage refills when empty or taken
  assign in_ready = (st_r.cnt != DEPTH[AW:0]);
  assign wr = in_valid && in_ready;
  assign fill = (!st_r.ov || out_ready) && (st_r.cnt != '0);
  assign rd = fill;
  assign out_valid = st_r.ov;
  assign out_data = st_r.od;
  // next state
  always_comb
  begin
    st_nxt = st_r;
    if (wr)
      st_nxt.wp = st_r.wp + 1'b1;
    if (rd)
    begin
      st_nxt.rp = st_r.rp + 1'b1;
      st_nxt.od = mem_r[st_r.rp];
    end
    if (st_r.ov && out_ready)
      st_nxt.ov = 1'b0;
    if (rd)
      st_nxt.ov = 1'b1;
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    if (reset)
      st_nxt = '0;
  end
  // registers
  always_ff @(posedge ref_clk)
  begin
    st_r <= st_nxt;
    if (wr)
      mem_r[st_r.wp] <= in_data;
  end
endmodule

// [logic/tbx_ctrl.sv]
// Purpose: control logic of a two-wire power-and-data bus transceiver
// Assumes: 10 MHz ref_clk; pins and comparator outputs are asynchronous
// Notes: analog parts (slew, thresholds, filter) are outside this block
// Notes on behaviour
// - transmitter enabled only while disable input low
// - receiver always runs, ignoring transmitter state
// - each data fall drives opposite polarity pulse
// - each data rise releases both line pins
// - on release, close termination switch to pin a
// - switch opens on timeout, data low, disable high
// - watchdog active only while guard enable low
// - guard enable pulled weakly low inside
// - long low beyond limit releases both pins
// - every data transition restarts watchdog interval
// - receive output low on leading threshold crossing
// - receive output released on trailing threshold crossing
`include "tbx_cfg.svh"
module tbx_ctrl
  import tbx_pkg::*;
#(
  parameter int TERM_CYCLES = `TBX_TERM_CYCLES,
  parameter int GUARD_CYCLES = `TBX_GUARD_CYCLES
)
(
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset, // sync reset, active high
  input wire logic tx_disable, // transmit disable pin
  input wire logic ser_in, // serial data input pin
  input wire logic long_low_guard_enable_n, // watchdog enable pin, active low
  output logic guard_pull_oe, // weak pulldown on guard enable pin
  input wire logic leading_edge_threshold, // comparator: |diff| above leading level
  input wire logic trailing_edge_threshold, // comparator: |diff| above trailing level
  output logic rx_out_o, // receive output level (always 0)
  output logic rx_out_oe, // receive output open-drain enable
  input wire logic line_pin_a_i, // line pin a readback (unused logic level)
  output logic line_pin_a_o, // line pin a drive level
  output logic line_pin_a_oe, // line pin a drive enable
  input wire logic line_pin_b_i, // line pin b readback
  output logic line_pin_b_o, // line pin b drive level
  output logic line_pin_b_oe, // line pin b drive enable
  output logic term_switch, // termination switch closed
  output logic fifo_full // edge queue has room (high = not full)
);
  typedef struct packed {
    logic [1:0] dis_s;
    logic [1:0] din_s;
    logic [1:0] wd_s;
    logic [1:0] lead_s;
    logic [1:0] trail_s;
    logic din_d;
    logic pol;
    tbx_drv_t drv;
    logic guard_trip;
    logic [`TBX_CNT_W-1:0] term_cnt;
    logic [`TBX_CNT_W-1:0] wd_cnt;
    logic rx_low;
    logic a_o;
    logic b_o;
    logic drv_oe;
    logic term;
  } tbx_st_t;
  tbx_st_t st_r;
  tbx_st_t st_nxt;
  logic fall;
  logic rise;
  logic q_valid;
  logic q_ready;
  logic q_data;
  logic ev_valid;
  logic ev_fall;
  logic [`TBX_CNT_W-1:0] term_lim;
  logic [`TBX_CNT_W-1:0] guard_lim;
  assign term_lim = TERM_CYCLES[`TBX_CNT_W-1:0];
  assign guard_lim = GUARD_CYCLES[`TBX_CNT_W-1:0];
  // edges on the synchronised data input
  assign fall = st_r.din_d && !st_r.din_s[1];
  assign rise = !st_r.din_d && st_r.din_s[1];
  // edges queue up so that a burst is never lost; drain one per cycle
  assign q_valid = fall || rise;
  assign q_data = fall;
  assign q_ready = 1'b1;
  tbx_fifo #(.WIDTH(1), .DEPTH(`TBX_FIFO_DEPTH)) u_edges (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(q_valid),
    .in_ready(fifo_full),
    .in_data(q_data),
    .out_valid(ev_valid),
    .out_ready(q_ready),
    .out_data(ev_fall)
  );
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // two-flop synchronisers for every asynchronous input
    st_nxt.dis_s = {st_r.dis_s[0], tx_disable};
    st_nxt.din_s = {st_r.din_s[0], ser_in};
    st_nxt.wd_s = {st_r.wd_s[0], long_low_guard_enable_n};
    st_nxt.lead_s = {st_r.lead_s[0], leading_edge_threshold};
    st_nxt.trail_s = {st_r.trail_s[0], trailing_edge_threshold};
    st_nxt.din_d = st_r.din_s[1];
    // watchdog counts while low and enabled, restarts on any edge
    if (fall || rise)
    begin
      st_nxt.wd_cnt = '0;
      st_nxt.guard_trip = 1'b0;
    end
    else if (!st_r.wd_s[1] && !st_r.din_s[1] && !st_r.guard_trip)
    begin
      if (st_r.wd_cnt >= guard_lim - 1'b1)
        st_nxt.guard_trip = 1'b1;
      else
        st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
    end
    else if (st_r.wd_s[1])
      st_nxt.wd_cnt = '0;
    // drive state follows the queued edges
    case (st_r.drv)
      TBX_IDLE:
      begin
        if (ev_valid && ev_fall)
        begin
          st_nxt.pol = !st_r.pol;
          st_nxt.drv = TBX_DRIVE;
        end
      end
      TBX_DRIVE:
      begin
        if (ev_valid && !ev_fall)
        begin
          st_nxt.drv = TBX_HOLD;
          st_nxt.term_cnt = '0;
        end
        else if (ev_valid && ev_fall)
          st_nxt.pol = !st_r.pol;
        else if (st_nxt.guard_trip)
        begin
          st_nxt.drv = TBX_HOLD;
          st_nxt.term_cnt = '0;
        end
      end
      TBX_HOLD:
      begin
        st_nxt.term_cnt = st_r.term_cnt + 1'b1;
        if (ev_valid && ev_fall)
        begin
          st_nxt.pol = !st_r.pol;
          st_nxt.drv = TBX_DRIVE;
        end
        else if (st_r.term_cnt >= term_lim - 1'b1 || st_r.dis_s[1])
          st_nxt.drv = TBX_IDLE;
      end
      default:
        st_nxt.drv = TBX_IDLE;
    endcase
    // registered pin drive; transmitter gated by disable input
    st_nxt.drv_oe = (st_nxt.drv == TBX_DRIVE) && !st_r.dis_s[1];
    st_nxt.a_o = st_nxt.pol;
    st_nxt.b_o = !st_nxt.pol;
    // switch only while driver released; host keeps disable low meanwhile
    st_nxt.term = (st_nxt.drv == TBX_HOLD) && !st_r.dis_s[1];
    // receiver runs regardless of transmitter; leading sets, trailing drop clears
    if (st_r.lead_s[1])
      st_nxt.rx_low = 1'b1;
    else if (!st_r.trail_s[1])
      st_nxt.rx_low = 1'b0;
    if (reset)
    begin
      st_nxt = '0;
      st_nxt.drv = TBX_IDLE;
      st_nxt.pol = `TBX_POL_INIT;
      // pins stay complementary even in reset, so the pair never shows equal levels
      st_nxt.a_o = `TBX_POL_INIT;
      st_nxt.b_o = !`TBX_POL_INIT;
      st_nxt.din_d = 1'b1;
      st_nxt.din_s = 2'b11;
      st_nxt.dis_s = 2'b11;
    end
  end
  // state register
  always_ff @(posedge ref_clk)
  begin
    st_r <= st_nxt;
  end
  // outputs straight from flip-flops, except rx_out_o and guard_pull_oe, tied to constants, and fifo_full, decoded from the queue count
  assign line_pin_a_o = st_r.a_o;
  assign line_pin_b_o = st_r.b_o;
  assign line_pin_a_oe = st_r.drv_oe;
  assign line_pin_b_oe = st_r.drv_oe;
  assign term_switch = st_r.term;
  assign rx_out_o = 1'b0;
  assign rx_out_oe = st_r.rx_low;
  assign guard_pull_oe = 1'b1;
endmodule

// [tb/tbx_far_model.sv]
// Purpose: far side of the line and the host pins
// Assumes: own drive shows on the line
// Notes: a floating guard pin sits at the pulldown
module tbx_far_model
(
  input wire logic a_oe, // own drive
  input wire logic remote, // remote pulse
  input wire logic guard_off, // host ties guard high
  input wire logic pull_oe, // device pulldown
  output logic guard_n, // guard pin level
  output logic lead, // leading comparator
  output logic trail // trailing comparator
);
  timeunit 1ns;
  timeprecision 1ns;
  // undriven pin falls to the pulldown
  assign guard_n = guard_off | ~pull_oe;
  // both comparators see any pulse
  assign lead = remote | a_oe;
  assign trail = remote | a_oe;
endmodule

// [tb/tbx_ctrl_properties.sv]
// Purpose: port checks for the transceiver control
// Assumes: bound into every tbx_ctrl
// Notes: slack follows the synchroniser latency
module tbx_ctrl_chk
#(
  parameter int TERM_CYCLES = 20,
  parameter int GUARD_CYCLES = 200
)
(
  input wire logic ref_clk, // clock
  input wire logic reset, // reset
  input wire logic tx_disable, // tx off
  input wire logic ser_in, // data
  input wire logic long_low_guard_enable_n, // guard
  input wire logic leading_edge_threshold, // lead
  input wire logic trailing_edge_threshold, // trail
  input wire logic rx_out_oe, // rx pull
  input wire logic line_pin_a_o, // a level
  input wire logic line_pin_a_oe, // a drive
  input wire logic line_pin_b_o, // b level
  input wire logic line_pin_b_oe, // b drive
  input wire logic term_switch // switch
);
  timeunit 1ns;
  timeprecision 1ns;
  int term_cnt_r;
  int low_cnt_r;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // run lengths, counted since an unroll would be too long
  always_ff @(posedge ref_clk)
  begin
    term_cnt_r <= (reset || !term_switch) ? 0 : term_cnt_r + 1;
    low_cnt_r <= (reset || ser_in || long_low_guard_enable_n) ? 0 : low_cnt_r + 1;
  end
  chk_tx_off: assert property (tx_disable [*5] |-> !line_pin_a_oe && !term_switch)
    else $error("drive while disabled");
  chk_pin_pair: assert property (line_pin_a_oe == line_pin_b_oe && line_pin_b_o != line_pin_a_o)
    else $error("pins not paired");
  chk_term_hiz: assert property (term_switch |-> !line_pin_a_oe)
    else $error("switch closed while driving");
  chk_term_close: assert property ($fell(line_pin_a_oe) && !tx_disable && !$past(tx_disable, 5)
    |-> ##[0:1] term_switch)
    else $error("switch not closed");
  chk_term_limit: assert property (term_cnt_r <= TERM_CYCLES)
    else $error("switch held too long");
  chk_rx_lead: assert property (leading_edge_threshold [*5] |-> rx_out_oe)
    else $error("rx not pulled");
  chk_rx_trail: assert property (!trailing_edge_threshold [*5] |-> !rx_out_oe)
    else $error("rx not released");
  chk_guard_fire: assert property (low_cnt_r > GUARD_CYCLES + 10 |-> !line_pin_a_oe)
    else $error("long low still driven");
endmodule
bind tbx_ctrl tbx_ctrl_chk #(.TERM_CYCLES(TERM_CYCLES), .GUARD_CYCLES(GUARD_CYCLES)) u_chk (
  .ref_clk, .reset, .tx_disable, .ser_in, .long_low_guard_enable_n, .leading_edge_threshold,
  .trailing_edge_threshold, .rx_out_oe, .line_pin_a_o, .line_pin_a_oe, .line_pin_b_o,
  .line_pin_b_oe, .term_switch);

// [tb/tb.sv]
// Purpose: directed bench for the transceiver control
// Assumes: short switch and guard counts
// Notes: far side lives in tbx_far_model
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TERM = 20;
  localparam int GUARD = 200;
  logic ref_clk = 0;
  logic reset = 1;
  logic tx_disable = 0;
  logic ser_in = 1;
  logic remote = 0;
  logic guard_off = 0;
  logic guard_n, pull_oe, lead, trail, rx_o, rx_oe, a_o, a_oe, b_o, b_oe, term, room;
  int miscompares = 0;
  int n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  tbx_ctrl #(.TERM_CYCLES(TERM), .GUARD_CYCLES(GUARD)) dut (.ref_clk, .reset, .tx_disable,
    .ser_in, .long_low_guard_enable_n(guard_n), .guard_pull_oe(pull_oe),
    .leading_edge_threshold(lead), .trailing_edge_threshold(trail), .rx_out_o(rx_o),
    .rx_out_oe(rx_oe), .line_pin_a_i(a_o), .line_pin_a_o(a_o), .line_pin_a_oe(a_oe),
    .line_pin_b_i(b_o), .line_pin_b_o(b_o), .line_pin_b_oe(b_oe), .term_switch(term),
    .fifo_full(room));
  tbx_far_model far (.a_oe, .remote, .guard_off, .pull_oe, .guard_n, .lead, .trail);
  task automatic check(input logic seen, input logic exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  // the #1 lets edge updates settle before sampling
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic ser(input logic v, input int n);
    @(posedge ref_clk);
    ser_in <= v;
    wt(n);
  endtask
  task automatic t_pulses;
    ser(0, 10);
    check(a_o, 1, "first polarity");
    ser(1, 10);
    check(a_oe, 0, "not released");
    check(term, 1, "switch open");
    ser(0, 10);
    check(b_o, 1, "no alternation");
    check(term, 0, "switch held on fall");
    ser(1, TERM + 15);
    check(term, 0, "switch past time");
    check(room, 1, "queue refused");
  endtask
  task automatic t_guard;
    ser(0, GUARD + 30);
    check(a_oe, 0, "long low held");
    wt(50);
    check(a_oe, 0, "line came back");
    ser(1, 10);
    ser(0, 150);
    ser(1, 2);
    ser(0, 150);
    check(a_oe, 1, "guard not restarted");
    ser(1, 10);
    @(posedge ref_clk);
    guard_off <= 1'b1;
    ser(0, GUARD + 60);
    check(a_oe, 1, "guard acted when off");
    ser(1, 10);
    @(posedge ref_clk);
    guard_off <= 1'b0;
  endtask
  // disable cuts the switch short; receiver keeps going
  task automatic t_disable;
    ser(0, 10);
    ser(1, 10);
    @(posedge ref_clk);
    tx_disable <= 1'b1;
    wt(6);
    check(term, 0, "switch held");
    ser(0, 10);
    check(a_oe, 0, "drive while off");
    @(posedge ref_clk);
    remote <= 1'b1;
    wt(6);
    check(rx_oe, 1, "rx idle");
    check(rx_o, 0, "rx not low");
    @(posedge ref_clk);
    remote <= 1'b0;
    wt(6);
    check(rx_oe, 0, "rx held");
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    wt(2);
    t_pulses();
    t_guard();
    t_disable();
    close_out();
  end
  // about ten times the expected run
  initial
  begin
    #1_000_000;
    miscompares++;
    close_out();
  end
endmodule
